// ---- scmlo_pkg.sv ----
// package: opcodes, constants, states and carriers for the move/literal executor
package scmlo_pkg;

   localparam int          CELL_W       = 32;
   localparam int          LCACHE_N     = 16;
   localparam logic [31:0] CELL_BYTES   = 32'h0000_0004;
   localparam logic [31:0] ALIGN_MASK   = 32'hFFFF_FFFC;
   localparam logic [31:0] RST_LSP      = 32'h0000_0000;
   localparam logic [31:0] RST_SA       = 32'h0000_0000;
   localparam logic [31:0] RST_X        = 32'h0000_0000;
   localparam logic [31:0] EXP_MASK_SGL = 32'hFF80_0000;
   localparam logic [31:0] EXP_MASK_DBL = 32'hFFF0_0000;
   localparam logic [3:0]  NEG8_NIB     = 4'h8;
   localparam logic [31:0] POS8_VAL     = 32'h0000_0008;

   // ****************************************************
   // opcodes
   // ****************************************************
   localparam logic [7:0] OP_POP_X     = 8'hB8;
   localparam logic [7:0] OP_POP_SA    = 8'hBC;
   localparam logic [7:0] OP_PUSH_S0   = 8'h92;
   localparam logic [7:0] OP_PUSH_S1   = 8'h93;
   localparam logic [7:0] OP_PUSH_S2   = 8'h9E;
   localparam logic [7:0] OP_PUSH_CT   = 8'h94;
   localparam logic [7:0] OP_PUSH_MODE = 8'h91;
   localparam logic [7:0] OP_PUSH_LSP  = 8'h9D;
   localparam logic [7:0] OP_PUSH_SA   = 8'h9C;
   localparam logic [7:0] OP_PUSH_X    = 8'h98;
   localparam logic [7:0] OP_PUSH_LSTK = 8'h9A;
   localparam logic [7:0] OP_PUSH_B    = 8'h90;
   localparam logic [7:0] OP_PUSH_L    = 8'h4F;
   localparam logic [7:0] OP_REPLB     = 8'hDA;
   localparam logic [7:0] OP_REPLEXP   = 8'hB5;
   localparam logic [7:0] OP_RET       = 8'h6E;
   localparam logic [7:0] OP_RETI      = 8'h6F;
   localparam logic [7:0] OP_REV       = 8'hE4;
   localparam logic [7:0] OP_RND       = 8'hD1;
   localparam logic [3:0] NIB_POP_LR   = 4'hA;
   localparam logic [3:0] NIB_PUSH_GR  = 4'h7;
   localparam logic [3:0] NIB_PUSH_LR  = 4'h8;
   localparam logic [3:0] NIB_PUSH_N   = 4'h2;

   localparam logic [1:0] RND_NEAR = 2'h0;
   localparam logic [1:0] RND_ZERO = 2'h1;
   localparam logic [1:0] RND_POS  = 2'h2;
   localparam logic [1:0] RND_NEG  = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_LFILL  = 3'b001,
      ST_LIT    = 3'b010,
      ST_SAFILL = 3'b011,
      ST_GWAIT  = 3'b100,
      ST_REDO   = 3'b101
   } scmlo_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] opcode;
      logic [7:0] litByte;
   } scmlo_instr_t;

   typedef struct packed {
      logic        req;
      logic [31:0] addr;
   } scmlo_memreq_t;

endpackage

// ---- scmlo_core.sv ----
// executor for stack moves, literal pushes, returns, rotate and round
// ****************************************************
// ****************************************************
`timescale 1ns/1ps
module scmlo_core
   import scmlo_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire scmlo_instr_t  instr,
   input  wire logic          grpStart,
   input  wire logic [31:0]   grpNextPc,
   input  wire logic [31:0]   countReg,
   input  wire logic [31:0]   modeReg,
   input  wire logic [511:0]  sharedRegFile,
   input  wire logic [15:0]   sharedRegHeld,
   input  wire logic          floatWidthSelect,
   input  wire logic [1:0]    roundingSelect,
   input  wire logic [2:0]    guardRoundStickyExt,
   input  wire logic [31:0]   memRdData,
   input  wire logic          memRdAck,
   output scmlo_memreq_t      memReq,
   output logic               instrReady,
   output logic [31:0]        stackTop,
   output logic               carry,
   output logic               pcLoad,
   output logic [31:0]        pcValue,
   output logic               svcClear,
   output logic               roundedExc,
   output logic               grsClear,
   output logic               operandSpillFlag
);

   logic [1:0]    rstSync_r;
   logic          rstN;
   scmlo_state_t  state_r;
   scmlo_state_t  state_nxt;
   logic [7:0]    op_r;
   logic [7:0]    lit_r;
   logic [7:0]    curOp;
   logic [7:0]    curLit;
   logic [3:0]    idx;
   logic          doExec;
   logic          needFill;
   logic          gBlocked;
   logic          execGo;
   logic [31:0]   s0_r;
   logic [31:0]   s1_r;
   logic [31:0]   s2_r;
   logic [31:0]   s0Nxt;
   logic [31:0]   s1Nxt;
   logic [31:0]   s2Nxt;
   logic          isPush;
   logic [31:0]   lreg_r [LCACHE_N];
   logic [4:0]    lDepth_r;
   logic [31:0]   lsp_r;
   logic [31:0]   sa_r;
   logic [31:0]   x_r;
   logic [31:0]   nextPc_r;
   logic [32:0]   rndSum;
   logic          rndInc;
   logic [31:0]   expMask;
   logic [31:0]   byteIns;
   scmlo_memreq_t memReq_r;

   // ****************************************************
   // reset release
   // ****************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstN = rstSync_r[1];

   // ****************************************************
   // decode
   // ****************************************************
   assign curOp  = (state_r == ST_IDLE) ? instr.opcode : op_r;
   assign curLit = (state_r == ST_IDLE) ? instr.litByte : lit_r;
   assign idx    = curOp[3:0];
   assign doExec = ((state_r == ST_IDLE) && instr.valid) || (state_r == ST_REDO);

   always_comb begin
      needFill = 1'b0;
      if ((curOp[7:4] == NIB_POP_LR) || (curOp[7:4] == NIB_PUSH_LR)) begin
         needFill = ({1'b0, idx} >= lDepth_r);
      end else if ((curOp == OP_RET) || (curOp == OP_RETI) || (curOp == OP_PUSH_LSTK)) begin
         needFill = (lDepth_r == 5'h00);
      end
   end

   assign gBlocked = (curOp[7:4] == NIB_PUSH_GR) && (idx != 4'h0) && sharedRegHeld[idx];
   assign execGo   = doExec && !needFill && !gBlocked;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE, ST_REDO: begin
            if (!doExec) begin
               state_nxt = ST_IDLE;
            end else if (needFill) begin
               state_nxt = ST_LFILL;
            end else if (gBlocked) begin
               state_nxt = ST_GWAIT;
            end else if (curOp == OP_PUSH_L) begin
               state_nxt = ST_LIT;
            end else if (curOp == OP_POP_SA) begin
               state_nxt = ST_SAFILL;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         ST_LFILL: begin
            if (memRdAck) begin
               state_nxt = ST_REDO;
            end
         end
         ST_GWAIT: begin
            if (!sharedRegHeld[idx]) begin
               state_nxt = ST_REDO;
            end
         end
         ST_LIT, ST_SAFILL: begin
            if (memRdAck) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         state_r    <= ST_IDLE;
         op_r       <= 8'h00;
         lit_r      <= 8'h00;
         instrReady <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         instrReady <= (state_nxt == ST_IDLE);
         if ((state_r == ST_IDLE) && instr.valid) begin
            op_r  <= instr.opcode;
            lit_r <= instr.litByte;
         end
      end
   end

   // ****************************************************
   // memory reads: cache refill, cell literal, stack refill
   // ****************************************************
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         memReq_r <= '0;
         nextPc_r <= 32'h0000_0000;
      end else begin
         memReq_r.req <= (state_nxt == ST_LFILL) || (state_nxt == ST_LIT) ||
                         (state_nxt == ST_SAFILL);
         if (grpStart) begin
            nextPc_r <= grpNextPc;
         end
         if (state_r != state_nxt) begin
            case (state_nxt)
               ST_LFILL:  memReq_r.addr <= lsp_r + {25'h0, lDepth_r, 2'h0} + CELL_BYTES;
               ST_SAFILL: memReq_r.addr <= (s0_r & ALIGN_MASK) + CELL_BYTES;
               ST_LIT: begin
                  memReq_r.addr <= nextPc_r;
                  nextPc_r      <= nextPc_r + CELL_BYTES;
               end
               default: memReq_r.addr <= memReq_r.addr;
            endcase
         end
      end
   end
   assign memReq = memReq_r;

   // ****************************************************
   // operand stack next values
   // ****************************************************
   assign rndInc = (roundingSelect == RND_NEAR) ? (guardRoundStickyExt[2] &
                   (guardRoundStickyExt[1] | guardRoundStickyExt[0] | s0_r[0])) :
                   (roundingSelect == RND_POS) ? ((|guardRoundStickyExt) & !countReg[31]) :
                   (roundingSelect == RND_NEG) ? ((|guardRoundStickyExt) & countReg[31]) :
                   1'b0;
   assign rndSum  = {1'b0, s0_r} + {32'h0, rndInc};
   assign expMask = floatWidthSelect ? EXP_MASK_DBL : EXP_MASK_SGL;

   always_comb begin
      byteIns = s0_r;
      case (x_r[1:0])
         2'h0:    byteIns[31:24] = s1_r[7:0];
         2'h1:    byteIns[23:16] = s1_r[7:0];
         2'h2:    byteIns[15:8]  = s1_r[7:0];
         default: byteIns[7:0]   = s1_r[7:0];
      endcase
   end

   always_comb begin
      isPush = 1'b1;
      s0Nxt  = s0_r;
      s1Nxt  = s0_r;
      s2Nxt  = s1_r;
      case (curOp)
         OP_PUSH_S0:   s0Nxt = s0_r;
         OP_PUSH_S1:   s0Nxt = s1_r;
         OP_PUSH_S2:   s0Nxt = s2_r;
         OP_PUSH_CT:   s0Nxt = countReg;
         OP_PUSH_MODE: s0Nxt = modeReg;
         OP_PUSH_LSP:  s0Nxt = lsp_r;
         OP_PUSH_SA:   s0Nxt = sa_r;
         OP_PUSH_X:    s0Nxt = x_r;
         OP_PUSH_LSTK: s0Nxt = lreg_r[0];
         OP_PUSH_B:    s0Nxt = {24'h0, curLit};
         default: begin
            isPush = 1'b0;
            s1Nxt  = s2_r;
            s2Nxt  = s2_r;
            case (curOp[7:4])
               NIB_PUSH_LR: begin
                  isPush = 1'b1;
                  s0Nxt  = lreg_r[idx];
                  s1Nxt  = s0_r;
                  s2Nxt  = s1_r;
               end
               NIB_PUSH_GR: begin
                  isPush = 1'b1;
                  s0Nxt  = sharedRegFile[{idx, 5'h00} +: 32];
                  s1Nxt  = s0_r;
                  s2Nxt  = s1_r;
               end
               NIB_PUSH_N: begin
                  isPush = 1'b1;
                  s0Nxt  = (idx == NEG8_NIB) ? POS8_VAL : {{28{idx[3]}}, idx};
                  s1Nxt  = s0_r;
                  s2Nxt  = s1_r;
               end
               NIB_POP_LR: begin
                  s0Nxt = s1_r;
               end
               default: begin
                  case (curOp)
                     OP_POP_X, OP_POP_SA: s0Nxt = s1_r;
                     OP_REPLB:   s0Nxt = byteIns;
                     OP_REPLEXP: s0Nxt = (s1_r & ~expMask) | (s0_r & expMask);
                     OP_REV: begin
                        s0Nxt = s2_r;
                        s1Nxt = s0_r;
                        s2Nxt = s1_r;
                     end
                     OP_RND: begin
                        s0Nxt = rndSum[31:0];
                        s1Nxt = s1_r;
                     end
                     default: begin
                        s0Nxt = s0_r;
                        s1Nxt = s1_r;
                     end
                  endcase
               end
            endcase
         end
      endcase
   end

   // ****************************************************
   // operand stack and its address
   // ****************************************************
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         s0_r             <= 32'h0000_0000;
         s1_r             <= 32'h0000_0000;
         s2_r             <= 32'h0000_0000;
         sa_r             <= RST_SA;
         x_r              <= RST_X;
         operandSpillFlag <= 1'b0;
      end else if (execGo && (curOp != OP_PUSH_L)) begin
         s0_r <= s0Nxt;
         s1_r <= s1Nxt;
         s2_r <= s2Nxt;
         if (isPush) begin
            operandSpillFlag <= 1'b1;
         end
         if (curOp == OP_POP_X) begin
            x_r <= s0_r;
         end
         if (curOp == OP_POP_SA) begin
            sa_r             <= s0_r & ALIGN_MASK;
            operandSpillFlag <= 1'b0;
         end
      end else if ((state_r == ST_LIT) && memRdAck) begin
         s0_r             <= memRdData;
         s1_r             <= s0_r;
         s2_r             <= s1_r;
         operandSpillFlag <= 1'b1;
      end else if ((state_r == ST_SAFILL) && memRdAck) begin
         s2_r <= memRdData;
      end
   end
   assign stackTop = s0_r;

   // ****************************************************
   // local register cache
   // ****************************************************
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i < LCACHE_N; i++) begin
            lreg_r[i] <= 32'h0000_0000;
         end
         lDepth_r <= 5'h00;
         lsp_r    <= RST_LSP;
      end else if ((state_r == ST_LFILL) && memRdAck) begin
         lreg_r[lDepth_r[3:0]] <= memRdData;
         lDepth_r              <= lDepth_r + 5'h01;
      end else if (execGo && ((curOp == OP_PUSH_LSTK) || (curOp == OP_RET) ||
                              (curOp == OP_RETI))) begin
         for (int i = 0; i < LCACHE_N - 1; i++) begin
            lreg_r[i] <= lreg_r[i + 1];
         end
         lDepth_r <= lDepth_r - 5'h01;
      end else if (execGo && (curOp[7:4] == NIB_POP_LR)) begin
         lreg_r[idx] <= s0_r;
      end
   end

   // ****************************************************
   // flags and event outputs
   // ****************************************************
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         carry      <= 1'b0;
         pcLoad     <= 1'b0;
         pcValue    <= 32'h0000_0000;
         svcClear   <= 1'b0;
         roundedExc <= 1'b0;
         grsClear   <= 1'b0;
      end else begin
         pcLoad     <= execGo && ((curOp == OP_RET) || (curOp == OP_RETI));
         svcClear   <= execGo && (curOp == OP_RETI);
         grsClear   <= execGo && (curOp == OP_REPLEXP);
         roundedExc <= execGo && (curOp == OP_RND) && (rndSum[0] != s0_r[0]);
         if (execGo && ((curOp == OP_RET) || (curOp == OP_RETI))) begin
            pcValue <= lreg_r[0];
         end
         if (execGo && (curOp == OP_RND)) begin
            carry <= rndSum[32];
         end
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstN);

   property p_popx;
      execGo && (curOp == OP_POP_X) |=> (x_r == $past(s0_r)) && (s0_r == $past(s1_r));
   endproperty
   a_popx: assert property (p_popx) else $error("pointer pop wrong");

   property p_dup;
      execGo && (curOp == OP_PUSH_S2) |=> (s0_r == $past(s2_r)) && (s1_r == $past(s0_r));
   endproperty
   a_dup: assert property (p_dup) else $error("cell copy push wrong");

   property p_short8;
      execGo && (curOp == 8'h28) |=> (s0_r == POS8_VAL);
   endproperty
   a_short8: assert property (p_short8) else $error("short literal 1000 not eight");

   property p_byte;
      execGo && (curOp == OP_PUSH_B) |=> (s0_r == {24'h0, $past(curLit)});
   endproperty
   a_byte: assert property (p_byte) else $error("byte literal wrong");

   property p_rev;
      execGo && (curOp == OP_REV) |=> (s0_r == $past(s2_r)) && (s2_r == $past(s1_r));
   endproperty
   a_rev: assert property (p_rev) else $error("rotate wrong");

   property p_rexc;
      execGo && (curOp == OP_RND) |=> (roundedExc == (s0_r[0] != $past(s0_r[0])));
   endproperty
   a_rexc: assert property (p_rexc) else $error("rounded exception wrong");

   property p_reti;
      execGo && (curOp == OP_RETI) |=> svcClear && pcLoad && (pcValue == $past(lreg_r[0]));
   endproperty
   a_reti: assert property (p_reti) else $error("interrupt return wrong");

   property p_gstall;
      doExec && gBlocked |=> (state_r == ST_GWAIT) && $stable(s0_r);
   endproperty
   a_gstall: assert property (p_gstall) else $error("held shared register not stalled");

   property p_sa;
      execGo && (curOp == OP_POP_SA) |=> (sa_r[1:0] == 2'h0) && !operandSpillFlag;
   endproperty
   a_sa: assert property (p_sa) else $error("stack address load wrong");

endmodule

// ---- scmlo_mem_model.sv ----
// memory and fetch unit model answering refill and literal reads
`timescale 1ns/1ps
module scmlo_mem_model
   import scmlo_pkg::*;
(
   input  wire logic          clock,
   input  wire scmlo_memreq_t memReq,
   output logic [31:0]        memRdData,
   output logic               memRdAck,
   output int                 reads,
   output logic [31:0]        lastAddr
);
   int waitCnt = 0;
   initial begin
      memRdData = 32'h0000_0000;
      memRdAck  = 1'b0;
      reads     = 0;
      lastAddr  = 32'h0000_0000;
   end
   // ****************************************************
   // one read at a time; cells at addr bit 2 answer slowly
   // ****************************************************
   always @(posedge clock) begin
      memRdAck  <= 1'b0;
      memRdData <= ~memRdData;
      if (memReq.req === 1'b1 && !memRdAck) begin
         if (waitCnt >= (memReq.addr[2] ? 3 : 0)) begin
            memRdAck  <= 1'b1;
            memRdData <= memReq.addr ^ 32'h5A5A_0000;
            lastAddr  <= memReq.addr;
            reads     <= reads + 1;
            waitCnt   <= 0;
         end else begin
            waitCnt <= waitCnt + 1;
         end
      end
   end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the move and literal executor
`timescale 1ns/1ps
module tb_top;
   import scmlo_pkg::*;
   logic clock, nrst, grpStart, floatWidthSelect, memRdAck, instrReady, carry;
   logic pcLoad, svcClear, roundedExc, grsClear, operandSpillFlag;
   logic [31:0] grpNextPc, countReg, modeReg, memRdData, stackTop, pcValue, lastAddr, pcSeen;
   logic [511:0] sharedRegFile;
   logic [15:0]  sharedRegHeld;
   logic [1:0]   roundingSelect;
   logic [2:0]   guardRoundStickyExt;
   scmlo_instr_t  instr;
   scmlo_memreq_t memReq;
   int reads, error_cnt = 0, tests_run = 0, cyc = 0, excN = 0, grsN = 0, svcN = 0;

   scmlo_core u_scmlo_core (.clock(clock), .nrst(nrst), .instr(instr), .grpStart(grpStart),
      .grpNextPc(grpNextPc), .countReg(countReg), .modeReg(modeReg),
      .sharedRegFile(sharedRegFile), .sharedRegHeld(sharedRegHeld),
      .floatWidthSelect(floatWidthSelect), .roundingSelect(roundingSelect),
      .guardRoundStickyExt(guardRoundStickyExt), .memRdData(memRdData), .memRdAck(memRdAck),
      .memReq(memReq), .instrReady(instrReady), .stackTop(stackTop), .carry(carry),
      .pcLoad(pcLoad), .pcValue(pcValue), .svcClear(svcClear), .roundedExc(roundedExc),
      .grsClear(grsClear), .operandSpillFlag(operandSpillFlag));
   scmlo_mem_model u_scmlo_mem_model (.clock(clock), .memReq(memReq), .memRdData(memRdData),
      .memRdAck(memRdAck), .reads(reads), .lastAddr(lastAddr));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // ****************************************************
   // pulse monitors and hang guard
   // ****************************************************
   always @(posedge clock) begin
      cyc++;
      if (roundedExc === 1'b1) excN++;
      if (grsClear === 1'b1) grsN++;
      if (svcClear === 1'b1) svcN++;
      if (pcLoad === 1'b1) pcSeen = pcValue;
      if (cyc == 6000) begin
         error_cnt++;
         close_out();
      end
   end

   function automatic logic [31:0] mdat(input logic [31:0] a);
      return a ^ 32'h5A5A_0000;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic ex(input logic [7:0] op);
      int n;
      @(posedge clock);
      #1;
      n = 0;
      while (instrReady !== 1'b1 && n < 300) begin
         @(posedge clock);
         #1;
         n++;
      end
      instr.opcode = op;
      instr.valid  = 1'b1;
      @(posedge clock);
      #1;
      instr.valid = 1'b0;
      n = 0;
      while (instrReady !== 1'b1 && n < 300) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask

   task automatic t_short;
      for (int i = 0; i < 16; i++) begin
         ex({NIB_PUSH_N, 4'(i)});
         chk("short", (i == 8) ? 32'h0000_0008 : {{28{i[3]}}, 4'(i)}, stackTop);
      end
      chk("spill", 32'h0000_0001, {31'h0, operandSpillFlag});
      $display("test short done");
   endtask

   task automatic t_lit;
      instr.litByte = 8'hA5;
      ex(OP_PUSH_B);
      ex(OP_PUSH_B);
      chk("byte", 32'h0000_00A5, stackTop);
      @(posedge clock);
      #1;
      grpNextPc = 32'h0000_0200;
      grpStart  = 1'b1;
      @(posedge clock);
      #1;
      grpStart = 1'b0;
      ex(OP_PUSH_L);
      chk("cell0", mdat(32'h0000_0200), stackTop);
      ex(OP_PUSH_L);
      chk("cell1", mdat(32'h0000_0204), stackTop);
      $display("test literal done");
   endtask

   task automatic t_stack;
      ex(8'h21);
      ex(8'h22);
      ex(8'h23);
      ex(OP_REV);
      chk("rev", 32'h0000_0001, stackTop);
      ex(OP_PUSH_S2);
      chk("s2", 32'h0000_0002, stackTop);
      ex(OP_PUSH_S1);
      chk("s1", 32'h0000_0001, stackTop);
      ex(8'h27);
      ex(OP_PUSH_S0);
      chk("s0", 32'h0000_0007, stackTop);
      ex(OP_PUSH_CT);
      chk("count", countReg, stackTop);
      ex(OP_PUSH_MODE);
      chk("mode", modeReg, stackTop);
      ex(OP_PUSH_LSP);
      chk("lsp", RST_LSP, stackTop);
      $display("test stack done");
   endtask

   task automatic t_bytes;
      ex(8'h21);
      ex(OP_POP_X);
      ex(OP_PUSH_X);
      chk("ptr", 32'h0000_0001, stackTop);
      instr.litByte = 8'hFF;
      ex(OP_PUSH_B);
      ex(OP_PUSH_CT);
      ex(OP_REPLB);
      chk("replb", 32'h12FF_5678, stackTop);
      for (int w = 0; w < 2; w++) begin
         floatWidthSelect = w[0];
         ex(OP_PUSH_CT);
         ex(OP_PUSH_MODE);
         ex(OP_REPLEXP);
         chk("replexp", w ? 32'hABC4_5678 : 32'hABB4_5678, stackTop);
      end
      @(posedge clock);
      #1;
      chk("grsclr", 32'h0000_0002, 32'(grsN));
      $display("test bytes done");
   endtask

   task automatic t_sa;
      instr.litByte = 8'h47;
      ex(OP_PUSH_B);
      ex(OP_POP_SA);
      chk("spillclr", 32'h0000_0000, {31'h0, operandSpillFlag});
      chk("refill", 32'h0000_0048, lastAddr);
      ex(OP_PUSH_S2);
      chk("s2fill", mdat(32'h0000_0048), stackTop);
      ex(OP_PUSH_SA);
      chk("sa", 32'h0000_0044, stackTop);
      $display("test stack address done");
   endtask

   task automatic t_local;
      int r0;
      r0 = reads;
      ex(8'h82);
      chk("ldfill", mdat(32'h0000_000C), stackTop);
      chk("ldreads", 32'h0000_0003, 32'(reads - r0));
      ex(8'h25);
      ex(8'hA1);
      ex(8'h81);
      chk("r1", 32'h0000_0005, stackTop);
      r0 = reads;
      ex(8'h26);
      ex(8'hA4);
      chk("streads", 32'h0000_0002, 32'(reads - r0));
      ex(8'h84);
      chk("r4", 32'h0000_0006, stackTop);
      ex(OP_PUSH_LSTK);
      chk("lstk", mdat(32'h0000_0004), stackTop);
      ex(8'h80);
      chk("shift", 32'h0000_0005, stackTop);
      ex(OP_RET);
      repeat (2) @(posedge clock);
      #1;
      chk("ret", 32'h0000_0005, pcSeen);
      ex(OP_RETI);
      repeat (2) @(posedge clock);
      #1;
      chk("reti", mdat(32'h0000_000C), pcSeen);
      chk("svc", 32'h0000_0001, 32'(svcN));
      $display("test local done");
   endtask

   task automatic t_shared;
      realtime t0;
      sharedRegHeld = 16'h0009;
      t0 = $realtime;
      ex(8'h70);
      chk("g0", 32'h0000_0000, stackTop);
      chk("g0fast", 32'h0000_0001, {31'h0, ($realtime - t0) < 200.0});
      fork
         begin
            #400;
            sharedRegHeld = 16'h0000;
         end
      join_none
      t0 = $realtime;
      ex(8'h73);
      chk("g3", 32'hCAFE_0003, stackTop);
      chk("stall", 32'h0000_0001, {31'h0, ($realtime - t0) > 400.0});
      $display("test shared done");
   endtask

   task automatic t_round;
      guardRoundStickyExt = 3'b110;
      ex(8'h2F);
      ex(OP_RND);
      repeat (2) @(posedge clock);
      #1;
      chk("rnd", 32'h0000_0000, stackTop);
      chk("carry", 32'h0000_0001, {31'h0, carry});
      chk("exc", 32'h0000_0001, 32'(excN));
      guardRoundStickyExt = 3'b000;
      ex(8'h22);
      ex(OP_RND);
      repeat (2) @(posedge clock);
      #1;
      chk("rndsame", 32'h0000_0002, stackTop);
      chk("nocarry", 32'h0000_0000, {31'h0, carry});
      chk("noexc", 32'h0000_0001, 32'(excN));
      roundingSelect      = RND_POS;
      guardRoundStickyExt = 3'b001;
      ex(OP_RND);
      chk("rndpos", 32'h0000_0003, stackTop);
      roundingSelect = RND_NEG;
      ex(OP_RND);
      roundingSelect = RND_ZERO;
      ex(OP_RND);
      repeat (2) @(posedge clock);
      #1;
      chk("rndnegzero", 32'h0000_0003, stackTop);
      chk("exc2", 32'h0000_0002, 32'(excN));
      $display("test round done");
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      nrst = 1'b0;
      instr = '0;
      grpStart = 1'b0;
      grpNextPc = 32'h0000_0000;
      countReg = 32'h1234_5678;
      modeReg = 32'hABCD_EF01;
      sharedRegFile = '0;
      sharedRegFile[127:96] = 32'hCAFE_0003;
      sharedRegHeld = 16'h0000;
      floatWidthSelect = 1'b0;
      roundingSelect = RND_NEAR;
      guardRoundStickyExt = 3'b000;
      repeat (8) @(posedge clock);
      #1;
      nrst = 1'b1;
      t_short();
      t_lit();
      t_stack();
      t_bytes();
      t_sa();
      t_local();
      t_shared();
      t_round();
      close_out();
   end
endmodule
